// *** rtl/afe_serial_mode_control.sv ***
// serial-port register bank, power modes and sample-bus control of the front end

module afe_serial_mode_control #(
  parameter int WAKE_RX_CYCLES = afe_ctrl_pkg::WAKE_RX_CYC,
  parameter int WAKE_TX_CYCLES = afe_ctrl_pkg::WAKE_TX_CYC
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      sclk,
  input  wire logic                      din,
  input  wire logic                      cs_wake_n,
  input  wire logic [9:0]                tx_sample_bus,
  input  wire logic [9:0]                rx_conv_word,
  output logic      [9:0]                rx_sample_bus,
  output logic                           rx_sample_bus_oe,
  output logic                           tx_bus_pullup,
  output logic      [9:0]                inphase_tx_output,
  output logic      [9:0]                quadrature_tx_output,
  output logic                           tx_output_zero,
  output afe_ctrl_pkg::pwr_status_s      power_status,
  output logic                           shutdown_state,
  output logic                           wake_settled,
  output logic      [11:0]               aux_dac_one_level,
  output logic      [11:0]               aux_dac_two_level,
  output logic      [11:0]               aux_dac_three_level,
  output logic      [2:0]                aux_dac_on,
  output logic                           aux_adc_on,
  output logic                           aux_adc_start,
  output logic      [10:0]               aux_adc_control,
  output logic                           tx_full_scale_500mv,
  output logic      [5:0]                tx_inphase_offset_trim,
  output logic      [5:0]                tx_quadrature_offset_trim,
  output logic      [1:0]                tx_common_mode_code
);

  // ****************************************
  // functions
  // ****************************************
  function automatic afe_ctrl_pkg::pwr_state_e state_of(input logic [2:0] mode,
                                                       input logic       adc_off);
    afe_ctrl_pkg::pwr_state_e s;
    s = afe_ctrl_pkg::ST_OFF;
    case (mode)
      afe_ctrl_pkg::MODE_OFF: begin
        s = adc_off ? afe_ctrl_pkg::ST_SHUTDOWN : afe_ctrl_pkg::ST_OFF;
      end
      afe_ctrl_pkg::MODE_IDLE:    s = afe_ctrl_pkg::ST_IDLE;
      afe_ctrl_pkg::MODE_STANDBY_STATE:    s = afe_ctrl_pkg::ST_STANDBY;
      afe_ctrl_pkg::MODE_SLOW_RX: s = afe_ctrl_pkg::ST_SLOW_RX;
      afe_ctrl_pkg::MODE_SLOW_TX: s = afe_ctrl_pkg::ST_SLOW_TX;
      afe_ctrl_pkg::MODE_FAST_RX: s = afe_ctrl_pkg::ST_FAST_RX;
      afe_ctrl_pkg::MODE_FAST_TX: s = afe_ctrl_pkg::ST_FAST_TX;
      default:                    s = afe_ctrl_pkg::ST_FULL_DUPLEX;
    endcase
    return s;
  endfunction

  // fields: rx_adc, rx_bus, tx_dac, tx_bus, clk, ref
  function automatic afe_ctrl_pkg::pwr_status_s status_of(input afe_ctrl_pkg::pwr_state_e s);
    afe_ctrl_pkg::pwr_status_s p;
    p = '0;
    case (s)
      afe_ctrl_pkg::ST_SHUTDOWN:    p = 6'b000000;
      afe_ctrl_pkg::ST_OFF:         p = 6'b000011;
      afe_ctrl_pkg::ST_IDLE:        p = 6'b000011;
      afe_ctrl_pkg::ST_STANDBY:     p = 6'b000001;
      afe_ctrl_pkg::ST_SLOW_RX:     p = 6'b110011;
      afe_ctrl_pkg::ST_SLOW_TX:     p = 6'b001111;
      afe_ctrl_pkg::ST_FAST_RX:     p = 6'b111011;
      afe_ctrl_pkg::ST_FAST_TX:     p = 6'b101111;
      afe_ctrl_pkg::ST_FULL_DUPLEX: p = 6'b111111;
      default:                      p = 6'b000000;
    endcase
    return p;
  endfunction

  // ****************************************
  // serial clock domain
  // ****************************************
  logic                     link_rst;
  logic [4:0]               bit_cnt_reg;
  logic [15:0]              shift_reg;
  logic [15:0]              shift_next;
  logic [15:0]              hold_reg;
  logic                     word_tgl_reg;

  // select high restarts the bit count even with the serial clock stopped
  assign link_rst   = rst | cs_wake_n;
  assign shift_next = {shift_reg[14:0], din};

  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_reg <= '0;
    end else if (bit_cnt_reg != afe_ctrl_pkg::WORD_CNT) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      shift_reg    <= '0;
      hold_reg     <= '0;
      word_tgl_reg <= 1'b0;
    end else if (bit_cnt_reg != afe_ctrl_pkg::WORD_CNT) begin
      shift_reg <= shift_next;
      if (bit_cnt_reg == afe_ctrl_pkg::LAST_BIT_CNT) begin
        hold_reg     <= shift_next;
        word_tgl_reg <= ~word_tgl_reg;
      end
    end
  end

  // ****************************************
  // crossing into the core domain
  // ****************************************
  logic [4:0]               cs_pipe_reg;
  logic [2:0]               tgl_pipe_reg;
  logic                     pending_reg;
  afe_ctrl_pkg::cmd_word_s  cmd_cap_reg;
  logic                     word_new;
  logic                     cs_rise;
  logic                     apply;
  logic                     wake_evt;
  afe_ctrl_pkg::cmd_word_s  cmd;

  // hold_reg is quasi-static: it is read only after the toggle has crossed and
  // cannot change again until sixteen more serial clocks have arrived
  assign word_new = tgl_pipe_reg[1] ^ tgl_pipe_reg[2];
  // the select edge is delayed two extra cycles so the word is always seen first
  assign cs_rise  = cs_pipe_reg[3] & ~cs_pipe_reg[4];
  assign cmd      = word_new ? afe_ctrl_pkg::cmd_word_s'(hold_reg) : cmd_cap_reg;
  assign apply    = cs_rise & (pending_reg | word_new);
  assign wake_evt = cs_rise & ~(pending_reg | word_new) & shutdown_state;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_pipe_reg  <= afe_ctrl_pkg::CS_IDLE;
      tgl_pipe_reg <= '0;
    end else begin
      cs_pipe_reg  <= {cs_pipe_reg[3:0], cs_wake_n};
      tgl_pipe_reg <= {tgl_pipe_reg[1:0], word_tgl_reg};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pending_reg <= 1'b0;
      cmd_cap_reg <= '0;
    end else begin
      if (word_new) begin
        cmd_cap_reg <= afe_ctrl_pkg::cmd_word_s'(hold_reg);
      end
      pending_reg <= word_new ? ~cs_rise : (pending_reg & ~cs_rise);
    end
  end

  // ****************************************
  // register decode
  // ****************************************
  logic wr_wide;
  logic wr_short;
  logic wr_dac_one;
  logic wr_dac_two;
  logic wr_dac_three;
  logic wr_iofs;
  logic wr_qofs;
  logic wr_cm;
  logic wr_adc;
  logic wr_wake;

  assign wr_wide      = apply && cmd.sel == afe_ctrl_pkg::SEL_MODE_WIDE;
  assign wr_dac_one   = apply && cmd.sel == afe_ctrl_pkg::SEL_DAC_ONE;
  assign wr_dac_two   = apply && cmd.sel == afe_ctrl_pkg::SEL_DAC_TWO;
  assign wr_dac_three = apply && cmd.sel == afe_ctrl_pkg::SEL_DAC_THREE;
  assign wr_iofs      = apply && cmd.sel == afe_ctrl_pkg::SEL_IOFS;
  assign wr_qofs      = apply && cmd.sel == afe_ctrl_pkg::SEL_QOFS;
  assign wr_cm        = apply && cmd.sel == afe_ctrl_pkg::SEL_CM;
  assign wr_adc       = apply && cmd.sel == afe_ctrl_pkg::SEL_ADC;
  assign wr_short     = apply && cmd.sel == afe_ctrl_pkg::SEL_MODE_SHORT;
  assign wr_wake      = apply && cmd.sel == afe_ctrl_pkg::SEL_WAKE;

  // ****************************************
  // control registers
  // ****************************************
  logic [2:0]  mode_reg;
  logic        adc_pwr_off_reg;
  logic [2:0]  dac_pwr_off_reg;
  logic [2:0]  wake_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_reg            <= afe_ctrl_pkg::RST_MODE;
      adc_pwr_off_reg     <= 1'b0;
      dac_pwr_off_reg     <= '0;
      tx_full_scale_500mv <= 1'b0;
    end else if (wr_wide) begin
      mode_reg            <= cmd.payload[2:0];
      adc_pwr_off_reg     <= cmd.payload[afe_ctrl_pkg::BIT_ADC_PWR];
      dac_pwr_off_reg     <= cmd.payload[afe_ctrl_pkg::BIT_DAC_ONE_PWR +: 3];
      tx_full_scale_500mv <= cmd.payload[afe_ctrl_pkg::BIT_FULL_SCALE];
    end else if (wr_short) begin
      mode_reg <= cmd.payload[2:0];
    end else if (wake_evt) begin
      mode_reg <= wake_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_reg <= afe_ctrl_pkg::RST_WAKE;
    end else if (wr_wake && cmd.payload[2:0] != afe_ctrl_pkg::MODE_OFF) begin
      wake_reg <= cmd.payload[2:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aux_dac_one_level   <= afe_ctrl_pkg::RST_DAC_ONE;
      aux_dac_two_level   <= afe_ctrl_pkg::RST_DAC_ALT;
      aux_dac_three_level <= afe_ctrl_pkg::RST_DAC_ALT;
    end else begin
      if (wr_dac_one) begin
        aux_dac_one_level <= cmd.payload;
      end
      if (wr_dac_two) begin
        aux_dac_two_level <= cmd.payload;
      end
      if (wr_dac_three) begin
        aux_dac_three_level <= cmd.payload;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_inphase_offset_trim    <= '0;
      tx_quadrature_offset_trim <= '0;
      tx_common_mode_code       <= '0;
      aux_adc_control           <= '0;
      aux_adc_start             <= 1'b0;
    end else begin
      if (wr_iofs) begin
        tx_inphase_offset_trim <= cmd.payload[afe_ctrl_pkg::OFS_BITS-1:0];
      end
      if (wr_qofs) begin
        tx_quadrature_offset_trim <= cmd.payload[afe_ctrl_pkg::OFS_BITS-1:0];
      end
      if (wr_cm) begin
        tx_common_mode_code <= cmd.payload[afe_ctrl_pkg::CM_BITS-1:0];
      end
      if (wr_adc) begin
        aux_adc_control <= cmd.payload[afe_ctrl_pkg::ADC_CTRL_BITS-1:0];
      end
      aux_adc_start <= wr_adc;
    end
  end

  // ****************************************
  // power state
  // ****************************************
  afe_ctrl_pkg::pwr_state_e  state_now;
  logic                      shut_prev_reg;
  logic                      shut_exit;
  logic [16:0]               settle_cnt_reg;
  afe_ctrl_pkg::pwr_status_s status_now;

  assign state_now      = state_of(mode_reg, adc_pwr_off_reg);
  assign status_now     = status_of(state_now);
  assign shutdown_state = state_now == afe_ctrl_pkg::ST_SHUTDOWN;
  assign shut_exit      = shut_prev_reg & ~shutdown_state;
  // aux DACs hold their last state everywhere except shutdown
  // one turns a DAC off
  assign aux_dac_on     = ~dac_pwr_off_reg & {3{~shutdown_state}};
  assign aux_adc_on     = ~adc_pwr_off_reg & ~shutdown_state;
  assign wake_settled   = settle_cnt_reg == 17'h00000;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      power_status  <= '1;
      shut_prev_reg <= 1'b0;
    end else begin
      power_status  <= status_now;
      shut_prev_reg <= shutdown_state;
    end
  end

  // reference recharge after shutdown; informative only, nothing is gated by it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settle_cnt_reg <= '0;
    end else if (shut_exit) begin
      settle_cnt_reg <= status_now.rx_adc_on ? 17'(WAKE_RX_CYCLES)
                                             : 17'(WAKE_TX_CYCLES);
    end else if (!wake_settled) begin
      settle_cnt_reg <= settle_cnt_reg - 17'h00001;
    end
  end

  // ****************************************
  // sample buses
  // ****************************************
  logic [9:0] i_hold_reg;
  logic [9:0] last_conv_reg;

  assign rx_sample_bus_oe = power_status.rx_bus_on;
  assign tx_bus_pullup    = ~power_status.tx_bus_on;
  assign tx_output_zero   = ~power_status.tx_dac_on;

  always_ff @(negedge core_clk or posedge rst) begin
    if (rst) begin
      i_hold_reg <= afe_ctrl_pkg::TX_MID;
    end else if (!power_status.tx_bus_on) begin
      i_hold_reg <= afe_ctrl_pkg::TX_MID;
    end else begin
      i_hold_reg <= tx_sample_bus;
    end
  end

  // mid code for an idle path
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      inphase_tx_output    <= afe_ctrl_pkg::TX_MID;
      quadrature_tx_output <= afe_ctrl_pkg::TX_MID;
    end else if (!power_status.tx_bus_on) begin
      inphase_tx_output    <= afe_ctrl_pkg::TX_MID;
      quadrature_tx_output <= afe_ctrl_pkg::TX_MID;
    end else begin
      inphase_tx_output    <= i_hold_reg;
      quadrature_tx_output <= tx_sample_bus;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      last_conv_reg <= '0;
      rx_sample_bus <= '0;
    end else begin
      if (power_status.rx_adc_on) begin
        last_conv_reg <= rx_conv_word;
      end
      if (power_status.rx_bus_on) begin
        rx_sample_bus <= last_conv_reg;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_dac_level_write: assert property (
    wr_dac_one |=> aux_dac_one_level == $past(cmd.payload))
    else $error("dac one level not taken");

  a_bad_sel_hold: assert property (
    apply && cmd.sel > afe_ctrl_pkg::SEL_WAKE |=>
      $stable(mode_reg) && $stable(wake_reg) && $stable(aux_dac_two_level))
    else $error("undefined select changed state");

  a_wake_zero_ign: assert property (
    wr_wake && cmd.payload[2:0] == afe_ctrl_pkg::MODE_OFF |=> $stable(wake_reg))
    else $error("zero wake code accepted");

  a_shutdown_state_bus_off: assert property (
    shutdown_state |=> !rx_sample_bus_oe && tx_bus_pullup && tx_output_zero)
    else $error("shutdown left a bus active");

  a_shutdown_state_tx_drop: assert property (
    shutdown_state ##1 shutdown_state |=>
      inphase_tx_output == afe_ctrl_pkg::TX_MID &&
      quadrature_tx_output == afe_ctrl_pkg::TX_MID)
    else $error("held tx sample survived shutdown");

  a_q_pass_through: assert property (
    power_status.tx_bus_on |=> quadrature_tx_output == $past(tx_sample_bus))
    else $error("quadrature word not updated");

  a_rx_first_word: assert property (
    power_status.rx_bus_on |=> rx_sample_bus == $past(last_conv_reg))
    else $error("rx bus did not show last word");

  a_short_mode_wr: assert property (
    wr_short |=> $stable(adc_pwr_off_reg) && mode_reg == $past(cmd.payload[2:0]))
    else $error("short mode write wrong");

  a_adc_start_pulse: assert property (
    wr_adc |=> aux_adc_start ##1 !aux_adc_start)
    else $error("conversion start not one cycle");

  a_wake_mode_load: assert property (
    wake_evt |=> mode_reg == $past(wake_reg) ##1 !shutdown_state)
    else $error("wake did not enter selected mode");

  a_dac_pwr_bits: assert property (
    wr_wide && cmd.payload[2:0] != afe_ctrl_pkg::MODE_OFF |=>
      aux_dac_on == ~$past(cmd.payload[6:4]))
    else $error("dac power bits misapplied");

  a_cmd_in_shutdown_state: assert property (
    shutdown_state && wr_dac_three |=> aux_dac_three_level == $past(cmd.payload))
    else $error("command lost in shutdown");

  a_word_toggle: assert property (
    @(posedge sclk) disable iff (link_rst)
    bit_cnt_reg == afe_ctrl_pkg::LAST_BIT_CNT |=> word_tgl_reg != $past(word_tgl_reg))
    else $error("sixteenth bit did not complete word");

  c_wide_write: cover property (wr_wide);
  c_wake_event: cover property (wake_evt);
  c_rx_resume:  cover property ($rose(rx_sample_bus_oe));
  c_adc_start:  cover property (wr_adc);

endmodule

// *** rtl/afe_ctrl_pkg.sv ***
// constants, types and encodings shared by the front-end control logic
package afe_ctrl_pkg;

  // ****************************************
  // serial command word
  // ****************************************
  localparam int          PAYLOAD_BITS = 12;
  localparam int          SEL_BITS     = 4;
  localparam int          TX_BITS      = 10;
  localparam logic [4:0]  WORD_CNT     = 5'h10;
  localparam logic [4:0]  LAST_BIT_CNT = 5'h0f;

  localparam logic [3:0]  SEL_MODE_WIDE  = 4'h0;
  localparam logic [3:0]  SEL_DAC_ONE    = 4'h1;
  localparam logic [3:0]  SEL_DAC_TWO    = 4'h2;
  localparam logic [3:0]  SEL_DAC_THREE  = 4'h3;
  localparam logic [3:0]  SEL_IOFS       = 4'h4;
  localparam logic [3:0]  SEL_QOFS       = 4'h5;
  localparam logic [3:0]  SEL_CM         = 4'h6;
  localparam logic [3:0]  SEL_ADC        = 4'h7;
  localparam logic [3:0]  SEL_MODE_SHORT = 4'h8;
  localparam logic [3:0]  SEL_WAKE       = 4'h9;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_DAC_ONE_PWR = 4;
  localparam int BIT_FULL_SCALE  = 7;
  localparam int BIT_ADC_PWR     = 9;
  localparam int OFS_BITS        = 6;
  localparam int CM_BITS         = 2;
  localparam int ADC_CTRL_BITS   = 11;

  // ****************************************
  // operating mode codes
  // ****************************************
  localparam logic [2:0] MODE_OFF     = 3'h0;
  localparam logic [2:0] MODE_IDLE    = 3'h1;
  localparam logic [2:0] MODE_STANDBY_STATE    = 3'h2;
  localparam logic [2:0] MODE_SLOW_RX = 3'h3;
  localparam logic [2:0] MODE_SLOW_TX = 3'h4;
  localparam logic [2:0] MODE_FAST_RX = 3'h5;
  localparam logic [2:0] MODE_FAST_TX = 3'h6;
  localparam logic [2:0] MODE_FD      = 3'h7;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [11:0] RST_DAC_ONE = 12'h68c;
  localparam logic [11:0] RST_DAC_ALT = 12'h000;
  localparam logic [2:0]  RST_MODE    = 3'h7;
  localparam logic [2:0]  RST_WAKE    = 3'h7;
  localparam logic [9:0]  TX_MID      = 10'h200;
  localparam logic [4:0]  CS_IDLE     = 5'h1f;

  // ****************************************
  // timing
  // ****************************************
  localparam int CORE_MHZ    = 250;
  localparam int WAKE_RX_US  = 500;
  localparam int WAKE_TX_US  = 26;
  localparam int WAKE_RX_CYC = WAKE_RX_US * CORE_MHZ;
  localparam int WAKE_TX_CYC = WAKE_TX_US * CORE_MHZ;

  typedef enum {
    ST_SHUTDOWN, ST_OFF, ST_IDLE, ST_STANDBY, ST_SLOW_RX,
    ST_SLOW_TX, ST_FAST_RX, ST_FAST_TX, ST_FULL_DUPLEX
  } pwr_state_e;

  typedef struct packed {
    logic rx_adc_on;
    logic rx_bus_on;
    logic tx_dac_on;
    logic tx_bus_on;
    logic clk_on;
    logic ref_on;
  } pwr_status_s;

  typedef struct packed {
    logic [11:0] payload;
    logic [3:0]  sel;
  } cmd_word_s;

endpackage

// *** verification/host_serial_model.sv ***
// host-side serial master model for the control port
module host_serial_model (
  output logic sclk,
  output logic din,
  output logic cs_wake_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    din = 1'b0;
    cs_wake_n = 1'b1;
  end
  task automatic send(input logic [15:0] word, input int nbits);
    // gap keeps cs high well over eight core cycles
    #40;
    cs_wake_n = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      din = word[i];
      #7.5;
      // bit held across the rising edge
      sclk = 1'b1;
      #7.5;
      sclk = 1'b0;
    end
    // released line flips so a stale bit cannot pass
    din = ~din;
    #7.5;
    cs_wake_n = 1'b1;
  endtask
endmodule

// *** verification/afe_serial_mode_control_test.sv ***
// self-checking bench for the front-end serial control block
module afe_serial_mode_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0, rst = 1'b1, sclk, din, cs_wake_n, chk_tx = 1'b0;
  logic [9:0]  tx_sample_bus = 10'h000, rx_conv_word = 10'h000, d_prev, d_now;
  logic [9:0]  rx_sample_bus, inphase_tx_output, quadrature_tx_output;
  logic        rx_sample_bus_oe, tx_bus_pullup, tx_output_zero, shutdown_state;
  logic        wake_settled, aux_adc_on, aux_adc_start, tx_full_scale_500mv;
  logic [11:0] aux_dac_one_level, aux_dac_two_level, aux_dac_three_level, regs [16];
  logic [10:0] aux_adc_control;
  logic [5:0]  tx_inphase_offset_trim, tx_quadrature_offset_trim;
  logic [5:0]  pwr_tab [8] = '{6'h03, 6'h03, 6'h01, 6'h33, 6'h0f, 6'h3b, 6'h2f, 6'h3f};
  logic [2:0]  aux_dac_on;
  logic [1:0]  tx_common_mode_code;
  afe_ctrl_pkg::pwr_status_s power_status;
  int          n_mismatch = 0, n_tests = 0, n_start = 0, n_adc = 0, seed = 32'hcbad86bd;

  afe_serial_mode_control #(.WAKE_RX_CYCLES(20), .WAKE_TX_CYCLES(10))
    i_afe_serial_mode_control (.*);
  host_serial_model i_host_serial_model (.*);

  always #2 core_clk = ~core_clk;

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // model image follows each command, then waits for the core to apply it
  task automatic wr(input int sel, input logic [11:0] pl, input int nb = 16, input int w = 10);
    logic sd;
    sd = regs[0][2:0] == 3'h0 && regs[0][9];
    // a bare cs pulse in shutdown wakes into the stored state
    if (nb < 16 && sd) regs[0][2:0] = regs[9][2:0];
    // short register touches mode bits only
    else if (nb == 16 && sel == 8) regs[0][2:0] = pl[2:0];
    // decode, wake zero and undefined codes dropped
    else if (nb == 16 && sel < 10 && !(sel == 9 && pl[2:0] == 3'h0)) regs[sel] = pl;
    if (nb == 16 && sel == 7) n_adc++;
    i_host_serial_model.send({pl, 4'(sel)}, nb);
    repeat (w) @(negedge core_clk);
  endtask

  task automatic check_regs;
    check(aux_dac_one_level, regs[1]);
    check(aux_dac_two_level, regs[2]);
    check(aux_dac_three_level, regs[3]);
    check(tx_inphase_offset_trim, regs[4][5:0]);
    check(tx_quadrature_offset_trim, regs[5][5:0]);
    check(tx_common_mode_code, regs[6][1:0]);
    check(aux_adc_control, regs[7][10:0]);
    check(tx_full_scale_500mv, regs[0][7]);
    check(12'(n_start), 12'(n_adc));
  endtask

  task automatic check_pwr(input int m);
    check(power_status, pwr_tab[m]);
    check(rx_sample_bus_oe, pwr_tab[m][4]);
    check(tx_bus_pullup, !pwr_tab[m][2]);
    check(tx_output_zero, !pwr_tab[m][3]);
    check(aux_dac_on, 3'(~regs[0][6:4]));
    check(aux_adc_on, !regs[0][9]);
    if (!pwr_tab[m][2]) check(inphase_tx_output, afe_ctrl_pkg::TX_MID);
  endtask

  always @(posedge core_clk) if (aux_adc_start === 1'b1) n_start++;

  // i is taken on the fall, q on the rise, so the i output lags the bus by one word and q shows the current word
  always @(negedge core_clk) begin
    if (chk_tx) begin
      check(inphase_tx_output, d_prev);
      check(quadrature_tx_output, d_now);
    end
    d_prev = d_now;
    d_now = 10'($random(seed));
    tx_sample_bus <= d_now;
  end

  initial begin
    #200000;
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    for (int i = 0; i < 16; i++) regs[i] = 12'h000;
    regs[0] = 12'h007;
    regs[1] = afe_ctrl_pkg::RST_DAC_ONE;
    regs[9] = 12'h007;
    repeat (8) @(negedge core_clk);
    rst <= 1'b0;
    repeat (2) @(negedge core_clk);
    check_regs;
    check_pwr(7);
    // every select code except 0 once, top control bit kept clear
    for (int s = 1; s < 16; s++) wr(s, 12'($random(seed)) & 12'h7ff);
    check_regs;
    check_pwr(int'(regs[0][2:0]));
    wr(1, ~regs[1], 15);
    check_regs;
    for (int m = 0; m < 8; m++) begin
      wr(8, 12'h200 | 12'(m));
      check_pwr(m);
    end
    // reserved bits clear, unused bits set
    wr(0, 12'h30f | (12'($random(seed)) & 12'h0f0));
    check_regs;
    check_pwr(7);
    chk_tx = 1'b1;
    repeat (30) @(negedge core_clk);
    chk_tx = 1'b0;
    rx_conv_word <= 10'h2a5;
    wr(8, 12'h004);
    rx_conv_word <= 10'h15a;
    wr(8, 12'h007, 16, 0);
    for (int i = 0; i < 20; i++) begin
      @(negedge core_clk);
      if (rx_sample_bus_oe === 1'b1) break;
    end
    check(rx_sample_bus_oe, 1'b1);
    check(rx_sample_bus, 10'h2a5);
    @(negedge core_clk);
    check(rx_sample_bus, 10'h2a5);
    @(negedge core_clk);
    check(rx_sample_bus, 10'h15a);
    wr(9, 12'h005);
    wr(9, 12'h000);
    wr(0, 12'h200);
    check({shutdown_state, rx_sample_bus_oe, tx_bus_pullup, tx_output_zero, aux_dac_on,
           aux_adc_on}, 12'h0b0);
    wr(2, 12'($random(seed)));
    check_regs;
    wr(0, 12'h000, 0);
    check(wake_settled, 1'b0);
    check_pwr(5);
    for (int i = 0; i < 40; i++) begin
      @(negedge core_clk);
      if (wake_settled === 1'b1) break;
    end
    check(wake_settled, 1'b1);
    report_and_stop;
  end
endmodule
